// file: dv/gpi_chk.sv
// Port checker for the GPIO interrupt block.
// Assumes the bind below reaches every instance.
`timescale 1ns/1ps
module gpi_chk #(parameter [7:0] AFS_RST = 8'h00) (
  // Clock, reset, bus
  input wire aclk, aresetn,
  input wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire s_axi_rvalid, s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // Pins and interrupts
  input wire [7:0] pin_irq, hw_function_field,
  input wire combined_port_interrupt, converter_trigger_pin
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_comb_or: assert property (combined_port_interrupt == |pin_irq)
    else $error("combined line wrong");
  a_trig_pin: assert property (converter_trigger_pin == pin_irq[4])
    else $error("trigger wrong");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("no write answer");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("response dropped");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("reserved bits set");
  a_afs_reset: assert property ($rose(aresetn) |-> hw_function_field == AFS_RST)
    else $error("function select reset");
  a_mask_reset: assert property ($rose(aresetn) |-> pin_irq == 8'h00)
    else $error("irq after reset");
  // Main scenarios
  c_irq: cover property (combined_port_interrupt);
  c_trig: cover property (converter_trigger_pin);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule // gpi_chk
bind gpi_port_irq gpi_chk #(.AFS_RST(AFS_RST)) chk_i (.*);

// file: dv/gpi_pins.sv
// Pin-side model: drives the eight port pins.
// Assumes calls come from the bench's main thread.
`timescale 1ns/1ps
module gpi_pins (
  // Clock
  input wire aclk,
  // Pins
  output reg [7:0] pin_in
);
  // Pins move only just after an edge
  initial pin_in = 8'h00;
  task drv(input [7:0] v);
    begin
      @(posedge aclk);
      pin_in <= v;
    end
  endtask
endmodule // gpi_pins

// file: dv/tb_gpio_pin_interrupt_and_mode_select.sv
// Bench: table of sense modes, then mask, clear, reserved, unmapped, reset.
// Assumes gpi_defines.vh on the include path.
`timescale 1ns/1ps
`include "gpi_defines.vh"
module tb_gpio_pin_interrupt_and_mode_select;
  reg aclk = 1'b0, aresetn = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  reg [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  reg [31:0] s_axi_wdata = '0;
  reg [3:0] s_axi_wstrb = 4'hf;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] pin_in, hw_function_field, pin_irq;
  wire combined_port_interrupt, converter_trigger_pin;
  integer error_cnt = 0, n_checks = 0, i;
  reg [47:0] t [0:3];
  always #25 aclk = ~aclk;
  gpi_port_irq #(.AFS_RST(8'h80)) DUT (.*);
  gpi_pins PIN (.aclk(aclk), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////
  task chk(input string n, input [31:0] s, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("unexpected %s: expected %h seen %h", n, e, s);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Bus tasks; responses held ready, each wait bounded
  // Handshakes are judged on values settled mid-cycle, acted on after the edge
  task w(input [11:0] a, input [31:0] d, input [1:0] er = 2'b00);
    integer n;
    reg dn;
    reg a_ok;
    reg w_ok;
    reg [1:0] rs;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      dn = 1'b0;
      for (n = 0; !dn; n = n + 1) begin
        if (n > 40) error_cnt = error_cnt + 1;
        if (n > 40) wrap_up;
        @(negedge aclk);
        a_ok = s_axi_awvalid && s_axi_awready;
        w_ok = s_axi_wvalid && s_axi_wready;
        dn = s_axi_bvalid;
        rs = s_axi_bresp;
        @(posedge aclk);
        if (a_ok) s_axi_awvalid <= 1'b0;
        if (w_ok) s_axi_wvalid <= 1'b0;
      end
      chk("bresp", rs, er);
    end
  endtask
  task r(input [11:0] a, input [31:0] e, input [1:0] er = 2'b00);
    integer n;
    reg dn;
    reg ar_ok;
    reg [31:0] rd;
    reg [1:0] rs;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      dn = 1'b0;
      for (n = 0; !dn; n = n + 1) begin
        if (n > 40) error_cnt = error_cnt + 1;
        if (n > 40) wrap_up;
        @(negedge aclk);
        ar_ok = s_axi_arvalid && s_axi_arready;
        dn = s_axi_rvalid;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        @(posedge aclk);
        if (ar_ok) s_axi_arvalid <= 1'b0;
      end
      chk("rdata", rd, e);
      chk("rresp", rs, er);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Rows: sense, both, polarity, pins before, pins after, raw expected
  initial begin
    t[0] = 48'h00ff_000f_f0ff;
    t[1] = 48'h0000_ff0f_f0f0;
    t[2] = 48'h0000_000f_f00f;
    t[3] = 48'hff00_f000_bab5;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // Mask stays zero here, so raw shows unmasked detection
    for (i = 0; i < 4; i = i + 1) begin
      w(`GPI_OFS_SENSE, t[i][47:40]);
      w(`GPI_OFS_BOTH, t[i][39:32]);
      w(`GPI_OFS_POL, t[i][31:24]);
      PIN.drv(t[i][23:16]);
      repeat (5) @(posedge aclk);
      w(`GPI_OFS_CLR, 32'h0000_00ff);
      PIN.drv(t[i][15:8]);
      repeat (5) @(posedge aclk);
      r(`GPI_OFS_RAW, t[i][7:0]);
    end
    w(`GPI_OFS_MASK, 32'h0000_0014);
    chk("pin_irq", pin_irq, 8'h14);
    chk("trigger", converter_trigger_pin, 1'b1);
    r(`GPI_OFS_MIS, 32'h0000_0014);
    w(`GPI_OFS_MASK, 32'h0000_0000);
    chk("combined", combined_port_interrupt, 1'b0);
    r(`GPI_OFS_RAW, 32'h0000_00b5);
    // Partial clear of latched edges
    w(`GPI_OFS_SENSE, 32'h0000_0000);
    w(`GPI_OFS_BOTH, 32'h0000_00ff);
    PIN.drv(8'h45);
    repeat (5) @(posedge aclk);
    w(`GPI_OFS_CLR, 32'h0000_000f);
    r(`GPI_OFS_RAW, 32'h0000_00f0);
    w(`GPI_OFS_POL, 32'hffff_ffff);
    r(`GPI_OFS_POL, 32'h0000_00ff);
    w(12'h0800, 32'h0000_0001, `GPI_RESP_SLVERR);
    r(12'h0800, 32'h0000_0000, `GPI_RESP_SLVERR);
    w(`GPI_OFS_AFS, 32'h0000_003c);
    chk("hw_function", hw_function_field, 8'h3c);
    // Second reset in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    r(`GPI_OFS_AFS, 32'h0000_0080);
    r(`GPI_OFS_MASK, 32'h0000_0000);
    wrap_up;
  end
endmodule // tb_gpio_pin_interrupt_and_mode_select

// file: rtl/gpi_defines.vh
// Register offsets, reset values and field limits of the GPIO interrupt block.
// Assumes inclusion by bare name from the design file.
`ifndef GPI_DEFINES_VH
`define GPI_DEFINES_VH

// Register byte offsets
`define GPI_OFS_SENSE 12'h0404
`define GPI_OFS_BOTH 12'h0408
`define GPI_OFS_POL 12'h040c
`define GPI_OFS_MASK 12'h0410
`define GPI_OFS_RAW 12'h0414
`define GPI_OFS_MIS 12'h0418
`define GPI_OFS_CLR 12'h041c
`define GPI_OFS_AFS 12'h0420

// Field width and reset values
`define GPI_NPIN 8
`define GPI_RST_CFG 8'h00
`define GPI_AFS_RST_B 8'h80
`define GPI_AFS_RST_C 8'h0f
`define GPI_AFS_RST_OTHER 8'h00

// Bus answers
`define GPI_RESP_OKAY 2'b00
`define GPI_RESP_SLVERR 2'b10

`endif

// file: rtl/gpi_port_irq.v
// GPIO port interrupt detection, mode select and AXI4-Lite register slave.
// Assumes pin inputs synchronous to aclk; one clock, synchronous reset.
//
// Function
// - Both-edges set in edge mode: every edge flags, polarity ignored
// - Both-edges clear: polarity picks edge or level
// - Single edge comes from polarity bit
// - Polarity 1 rising/high, 0 falling/low
// - Mask 1 passes pin and combined interrupt
// - Mask 0 blocks interrupt, raw still records
// - All mask bits reset to zero
// - Raw status reads detected condition, mask-free
// - Masked status is raw AND mask
// - Clear writes of 1 reset edge latch
// - Converter pin unmasked event triggers converter
// - Function select 1 gives hardware control
// - Reset to software inputs, debug pins hardware
// - Any reset restores default function selection
// - Only bits 7:0 implemented, upper read zero
// - Sense 1 level, sense 0 edge
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "gpi_defines.vh"

module gpi_port_irq #(
  // Reset value of the function select; 8'h80 port B, 8'h0f port C
  parameter [7:0] AFS_RST = `GPI_AFS_RST_OTHER,
  // Pin index forwarded as converter trigger (port B bit 4)
  parameter integer TRIG_PIN = 4
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [11:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  output wire [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [11:0] s_axi_araddr,
  // AXI4-Lite read data
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  // Pins and function select
  input wire [7:0] pin_in,
  output wire [7:0] hw_function_field,
  // Interrupts and converter trigger
  output wire [7:0] pin_irq,
  output wire combined_port_interrupt,
  output wire converter_trigger_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  reg [7:0] sense_r;
  reg [7:0] both_r;
  reg [7:0] pol_r;
  reg [7:0] mask_r;
  reg [7:0] afs_r;
  reg [7:0] edge_r;
  reg [7:0] sync1_r;
  reg [7:0] sync2_r;
  reg [7:0] prev_r;
  reg [7:0] raw_nxt;
  wire [7:0] raw;
  wire [7:0] masked_status_field;
  wire [7:0] edge_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave state
  reg aw_held_r;
  reg w_held_r;
  reg [11:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;
  wire wr_fire;
  wire rd_fire;
  wire [11:0] wa;
  wire [31:0] wd;
  wire wlane0;
  reg rd_hit;
  reg [7:0] rd_val;
  reg wr_hit;

  // Address and data accepted separately; response waits for both
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Write happens the cycle both halves are present (held or arriving)
  assign wr_fire = !bvalid_r && (aw_held_r || s_axi_awvalid) && (w_held_r || s_axi_wvalid);
  assign wa = aw_held_r ? awaddr_r : s_axi_awaddr;
  assign wd = w_held_r ? wdata_r : s_axi_wdata;
  // Only the low byte carries fields, so only lane 0 matters
  assign wlane0 = w_held_r ? wstrb_r[0] : s_axi_wstrb[0];
  assign rd_fire = s_axi_arvalid && !rvalid_r;

  // Write address decode
  always @* begin
    case (wa)
      `GPI_OFS_SENSE, `GPI_OFS_BOTH, `GPI_OFS_POL, `GPI_OFS_MASK,
      `GPI_OFS_RAW, `GPI_OFS_MIS, `GPI_OFS_CLR, `GPI_OFS_AFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Read mux; upper 24 bits always zero
  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `GPI_OFS_SENSE: rd_val = sense_r;
      `GPI_OFS_BOTH: rd_val = both_r;
      `GPI_OFS_POL: rd_val = pol_r;
      `GPI_OFS_MASK: rd_val = mask_r;
      `GPI_OFS_RAW: rd_val = raw;
      `GPI_OFS_MIS: rd_val = masked_status_field;
      `GPI_OFS_CLR: rd_val = 8'h00;
      `GPI_OFS_AFS: rd_val = afs_r;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Write channel holding and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `GPI_RESP_OKAY;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? `GPI_RESP_OKAY : `GPI_RESP_SLVERR;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // Read answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `GPI_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_val};
      rresp_r <= rd_hit ? `GPI_RESP_OKAY : `GPI_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers; status registers ignore writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      sense_r <= `GPI_RST_CFG;
      both_r <= `GPI_RST_CFG;
      pol_r <= `GPI_RST_CFG;
      mask_r <= `GPI_RST_CFG;
      afs_r <= AFS_RST;
    end else if (wr_fire && wlane0) begin
      case (wa)
        `GPI_OFS_SENSE: sense_r <= wd[7:0];
        `GPI_OFS_BOTH: both_r <= wd[7:0];
        `GPI_OFS_POL: pol_r <= wd[7:0];
        `GPI_OFS_MASK: mask_r <= wd[7:0];
        `GPI_OFS_AFS: afs_r <= wd[7:0];
        default: sense_r <= sense_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; first stage feeds only the second
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
      prev_r <= 8'h00;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Per-pin edge qualification and level status
  genvar g;
  generate
    for (g = 0; g < `GPI_NPIN; g = g + 1) begin : g_pin
      wire rise = sync2_r[g] & ~prev_r[g];
      wire fall = ~sync2_r[g] & prev_r[g];
      // Both-edges overrides polarity; else polarity picks the edge
      assign edge_hit[g] = both_r[g] ? (rise | fall) :
        (pol_r[g] ? rise : fall);
      // Level mode follows the pin directly, so clearing cannot stick
      assign raw[g] = sense_r[g] ? (sync2_r[g] == pol_r[g]) : edge_r[g];
    end
  endgenerate

  // Edge latches: a new edge wins over a clear in the same cycle
  always @* begin
    raw_nxt = edge_r;
    if (wr_fire && wlane0 && wa == `GPI_OFS_CLR)
      raw_nxt = edge_r & ~wd[7:0];
    raw_nxt = raw_nxt | (edge_hit & ~sense_r);
  end

  always @(posedge aclk) begin
    if (!aresetn)
      edge_r <= 8'h00;
    else
      edge_r <= raw_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign masked_status_field = raw & mask_r;
  assign pin_irq = masked_status_field;
  assign combined_port_interrupt = |masked_status_field;
  assign converter_trigger_pin = masked_status_field[TRIG_PIN];
  assign hw_function_field = afs_r;

endmodule // gpi_port_irq
